// file: bench/jsp_hub_model.sv
// hub model: plays the debug_hub_mux side of one instrument link
// assumes a 50 MHz CLK to pace its test clock at 160 ns per period
`timescale 1ns/1ps
module jsp_hub_model (
  // pacing clock
  input wire logic clk,
  // hub link toward the instrument
  output logic tck,
  output logic tdi,
  output logic sel,
  output logic [6:0] addr,
  output logic cap,
  output logic shf,
  output logic upd,
  input wire logic tdo
);
  // idle link: test clock stands low, strobes off
  initial begin
    tck = 1'b0;
    tdi = 1'b0;
    sel = 1'b0;
    addr = 7'h00;
    {cap, shf, upd} = 3'b000;
  end

  // one test clock period; strobes hold 80 ns on each side of the rise
  task automatic tck_edge(input logic [2:0] csu, input logic din, output logic dout);
    @(posedge clk) #1;
    tck = 1'b0;
    {cap, shf, upd} = csu;
    tdi = din;
    repeat (4) @(posedge clk);
    #1 tck = 1'b1;
    dout = tdo; // host reads out at its rising edge
    // the next call's first edge completes the high half, keeping 160 ns
    repeat (3) @(posedge clk);
  endtask : tck_edge

  // capture, nsh shifts, optional update, then release the link
  task automatic frame(input logic [6:0] a, input logic [7:0] din, input int nsh,
                       input bit do_upd, output logic [7:0] dout);
    logic b;
    dout = 8'h00;
    // select changes just after an edge, never in the edge's own time step
    @(posedge clk) #1;
    sel = 1'b1;
    addr = a;
    tck_edge(3'b100, 1'b0, b);
    for (int i = 0; i < nsh; i++) begin
      tck_edge(3'b010, din[i % 8], b);
      dout[i % 8] = b;
    end
    if (do_upd) begin
      tck_edge(3'b001, 1'b0, b);
    end
    tck_edge(3'b000, ~tdi, b);
    @(posedge clk) #1;
    tck = 1'b0;
    sel = 1'b0;
    tdi = ~tdi; // released line shows no stale value
  endtask : frame
endmodule : jsp_hub_model

// file: bench/testbench.sv
// testbench for the source and probe instrument in both source modes
// assumes the hub model paces the link and the bench owns user side clocks
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
  localparam logic [6:0] IDX = 7'h05;
  localparam logic [6:0] IDX2 = 7'h06;
  localparam logic [7:0] INIT = 8'ha5;
  logic clk = 1'b0, rst = 1'b1, src_clk = 1'b0, src_ena = 1'b0;
  logic tck, tdi, sel, cap, shf, upd, tdo;
  logic [6:0] addr;
  logic [7:0] probe = 8'h3c, src, rd;
  int fail_count = 0, comparisons = 0;
  logic [7:0] src2;
  logic tdo2;
  // hub returns the serial output of the addressed instance
  wire logic hub_tdo = (addr == IDX2) ? tdo2 : tdo;

  // system clock 50 MHz and an unrelated source clock
  always #10 clk = ~clk;
  always #15 src_clk = ~src_clk;

  // device under test, synchronous source mode with enable
  jsp_top #(.PROBE_W(8), .SOURCE_W(8), .INDEX(IDX), .INIT_VAL({248'h0, INIT}),
    .SYNC_MODE(1'b1), .USE_ENA(1'b1)) u_jsp_top (
    .CLK(clk), .SYS_RST(rst), .JTAG_TCK(tck), .JTAG_TDI(tdi), .JTAG_SEL(sel),
    .JTAG_ADDR(addr), .JTAG_CAPTURE(cap), .JTAG_SHIFT(shf), .JTAG_UPDATE(upd),
    .JTAG_TDO(tdo), .PROBE(probe), .SOURCE_CLK(src_clk), .SOURCE_ENA(src_ena),
    .SOURCE(src));

  // second instance on the same hub, direct source mode; its enable must be ignored
  if (1'b1) begin : g_async
    jsp_top #(.PROBE_W(8), .SOURCE_W(8), .INDEX(IDX2), .INIT_VAL({248'h0, INIT}),
      .SYNC_MODE(1'b0), .USE_ENA(1'b1)) u_jsp_top (
      .CLK(clk), .SYS_RST(rst), .JTAG_TCK(tck), .JTAG_TDI(tdi), .JTAG_SEL(sel),
      .JTAG_ADDR(addr), .JTAG_CAPTURE(cap), .JTAG_SHIFT(shf), .JTAG_UPDATE(upd),
      .JTAG_TDO(tdo2), .PROBE(~probe), .SOURCE_CLK(src_clk), .SOURCE_ENA(~src_ena),
      .SOURCE(src2));
  end

  // far side of the link
  jsp_hub_model u_jsp_hub_model (.clk(clk), .tck(tck), .tdi(tdi), .sel(sel),
    .addr(addr), .cap(cap), .shf(shf), .upd(upd), .tdo(hub_tdo));

  // counts, verdict and end of run
  task automatic complete_run;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // bounded wait for the source bus to take an expected value
  task automatic wait_src(input logic [7:0] exp);
    int n;
    for (n = 0; n < 80 && src !== exp; n++) begin
      @(posedge clk);
    end
    `CHK(src, exp)
    if (src !== exp) begin
      complete_run();
    end
  endtask : wait_src

  // source must hold its value for a stretch of cycles
  task automatic hold_src(input logic [7:0] exp);
    repeat (60) @(posedge clk);
    `CHK(src, exp)
  endtask : hold_src

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    `CHK(src, INIT)
    `CHK(tdo, 1'b0)
    `CHK(src2, INIT)
    repeat (4) @(posedge clk);
    // read probe and write a word while the source enable is low
    u_jsp_hub_model.frame(IDX, 8'h5a, 8, 1'b1, rd);
    `CHK(rd, 8'h3c)
    hold_src(INIT);
    #1 src_ena = 1'b1;
    wait_src(8'h5a);
    // the other instance answers and takes its word at once; this one ignores it
    u_jsp_hub_model.frame(IDX2, 8'hff, 8, 1'b1, rd);
    `CHK(rd, 8'hc3)
    `CHK(src2, 8'hff)
    hold_src(8'h5a);
    // partial shift is discarded at update
    u_jsp_hub_model.frame(IDX, 8'h0f, 5, 1'b1, rd);
    hold_src(8'h5a);
    // probe moves after capture; read shows the captured sample
    fork
      u_jsp_hub_model.frame(IDX, 8'hc3, 8, 1'b1, rd);
      begin
        repeat (20) @(posedge clk);
        #1 probe = 8'h96;
      end
    join
    `CHK(rd, 8'h3c)
    wait_src(8'hc3);
    // extra shifts: the last eight bits win, tdo returns the first bits shifted in
    u_jsp_hub_model.frame(IDX, 8'h81, 12, 1'b1, rd);
    `CHK(rd[3:0], 4'h1)
    `CHK(rd[7:4], 4'h9)
    wait_src(8'h18);
    `CHK(src2, 8'hff)
    complete_run();
  end
endmodule : testbench

// file: pkg/jsp_consts.svh
// constants for the jtag source and probe instrument
// assumes one hub delivers a 7-bit instance address to every instance
`ifndef JSP_CONSTS_SVH
`define JSP_CONSTS_SVH

// widest source or probe bus and number of addressable instances
`define JSP_MAX_W 256
`define JSP_MAX_INST 128
`define JSP_ADDR_W 7
// width of the shift counter, wide enough to count to JSP_MAX_W
`define JSP_CNT_W 9

// positions of the hub signals in the synchroniser vector
`define JSP_B_TCK 0
`define JSP_B_TDI 1
`define JSP_B_SEL 2
`define JSP_B_CAP 3
`define JSP_B_SHF 4
`define JSP_B_UPD 5
`define JSP_B_ADR 6
`define JSP_NSYNC 13

// reset values
`define JSP_RST_TGL 1'b0

`endif

// file: pkg/jsp_pkg.sv
// types shared by the source and probe instrument
// assumes jsp_consts.svh is available on the include path
package jsp_pkg;

  // chain state: waiting for capture, shifting, shifted full length
  typedef enum logic [1:0] {
    JSP_IDLE,
    JSP_SHIFT,
    JSP_FULL
  } jsp_state_t;

endpackage : jsp_pkg

// file: pkg/jsp_src_if.sv
// carrier for a finished source word from the chain to the source clock side
// assumes the word stays stable for many cycles after each request toggle
`timescale 1ns/1ps
interface jsp_src_if #(
  parameter int SOURCE_W = 32
);
  logic req_tgl;
  logic [SOURCE_W-1:0] data;

  modport tx (output req_tgl, output data);
  modport rx (input req_tgl, input data);
endinterface : jsp_src_if

// file: rtl/jsp_src_sync.sv
// source register in the user source clock domain
// assumes data is held stable by the sender from its toggle to the next toggle
`timescale 1ns/1ps
`include "jsp_consts.svh"
module jsp_src_sync import jsp_pkg::*; #(
  parameter int SOURCE_W = 32,
  parameter logic [`JSP_MAX_W-1:0] INIT_VAL = '0,
  parameter bit USE_ENA = 1'b0
) (
  // clock and reset
  input wire logic src_clk,
  input wire logic sys_rst,
  // clock enable for the source registers
  input wire logic src_ena,
  // word from the chain
  jsp_src_if.rx link,
  // registered source value
  output logic [SOURCE_W-1:0] src_out
);

  typedef struct packed {
    logic t1;
    logic t2;
    logic t3;
    logic seen;
    logic [SOURCE_W-1:0] src;
  } jsp_sync_st_t;

  jsp_sync_st_t q;
  jsp_sync_st_t n;
  logic ena_ok;
  logic load;

  // enable only qualifies when it was built in
  assign ena_ok = src_ena || !USE_ENA;
  assign load = (q.t2 == q.t3) && (q.t3 != q.seen) && ena_ok;

  // toggle synchroniser and source load
  always_comb begin
    n = q;
    n.t1 = link.req_tgl;
    n.t2 = q.t1;
    n.t3 = q.t2;
    if (load) begin
      n.seen = q.t3;
      n.src = link.data;
    end
  end

  // state register, source starts at its build-time value
  always_ff @(posedge src_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{t1: `JSP_RST_TGL, t2: `JSP_RST_TGL, t3: `JSP_RST_TGL,
             seen: `JSP_RST_TGL, src: INIT_VAL[SOURCE_W-1:0]};
    end else begin
      q <= n;
    end
  end

  assign src_out = q.src;

  property p_sync_load;
    @(posedge src_clk) disable iff (sys_rst)
      load |=> (q.src == $past(link.data));
  endproperty
  a_sync_load: assert property (p_sync_load) else $error("source word not loaded");

  property p_ena_hold;
    @(posedge src_clk) disable iff (sys_rst)
      (USE_ENA && !src_ena) |=> $stable(q.src) && $stable(q.seen);
  endproperty
  a_ena_hold: assert property (p_ena_hold) else $error("source moved while disabled");

endmodule : jsp_src_sync

// file: rtl/jsp_top.sv
// jtag source and probe instrument, one instance behind the debug hub
// assumes the debug_hub_mux drives tck, tdi, select, address and the
// capture, shift and update strobes, all asynchronous to CLK
//
// Behaviour
// - the probe bus width is a build parameter from 1 to 256 bits.
// - the source bus width is a build parameter from 1 to 256 bits.
// - the hub address is 7 bits wide so up to 128 instances share one hub.
// - the instance drives its source bus and samples its probe bus.
// - source and probe values travel through a serial chain shifted by the host.
// - a capture samples the probe in one cycle and an update writes the source in one.
// - each instance carries a build index and answers only when the hub addresses it.
// - the source shows its build-time initial value until the first host write.
// - in synchronous mode the source is registered in the user source clock domain.
// - the source clock enable is used only when synchronous mode is also built.
// - all traffic reaches the instance through the debug_hub_mux select and address.
// - in synchronous mode new source data is loaded on the source clock.
// - in synchronous mode the source enable gates the source registers so they load only while it is high.
`timescale 1ns/1ps
`include "jsp_consts.svh"
module jsp_top import jsp_pkg::*; #(
  parameter int PROBE_W = 32,
  parameter int SOURCE_W = 32,
  parameter logic [`JSP_ADDR_W-1:0] INDEX = '0,
  parameter logic [`JSP_MAX_W-1:0] INIT_VAL = '0,
  parameter bit SYNC_MODE = 1'b0,
  parameter bit USE_ENA = 1'b0
) (
  // system clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // debug hub link
  input wire logic JTAG_TCK,
  input wire logic JTAG_TDI,
  input wire logic JTAG_SEL,
  input wire logic [`JSP_ADDR_W-1:0] JTAG_ADDR,
  input wire logic JTAG_CAPTURE,
  input wire logic JTAG_SHIFT,
  input wire logic JTAG_UPDATE,
  output logic JTAG_TDO,
  // user probe side
  input wire logic [PROBE_W-1:0] PROBE,
  // user source side
  input wire logic SOURCE_CLK,
  input wire logic SOURCE_ENA,
  output logic [SOURCE_W-1:0] SOURCE
);

  localparam int CHAIN_W = (PROBE_W > SOURCE_W) ? PROBE_W : SOURCE_W;

  // build-time limits on the bus widths
  if (PROBE_W < 1 || PROBE_W > `JSP_MAX_W) begin : g_bad_probe
    $error("probe width out of range");
  end
  if (SOURCE_W < 1 || SOURCE_W > `JSP_MAX_W) begin : g_bad_source
    $error("source width out of range");
  end

  typedef struct packed {
    logic [`JSP_NSYNC-1:0] s1;
    logic [`JSP_NSYNC-1:0] s2;
    logic [`JSP_NSYNC-1:0] s3;
    logic tck_lvl;
    jsp_state_t st;
    logic [`JSP_CNT_W-1:0] cnt;
    logic [CHAIN_W-1:0] sh;
    logic tdo;
    logic [SOURCE_W-1:0] src;
    logic xreq;
  } jsp_top_st_t;

  jsp_top_st_t q;
  jsp_top_st_t n;
  logic rise;
  logic hit;
  logic cap_s;
  logic shf_s;
  logic upd_s;
  logic tdi_s;
  logic [SOURCE_W-1:0] sync_src;

  jsp_src_if #(.SOURCE_W(SOURCE_W)) xfer ();

  // true when the hub selects this instance by its index
  function automatic logic addr_hit(input logic [`JSP_NSYNC-1:0] v);
    addr_hit = v[`JSP_B_SEL] && (v[`JSP_B_ADR +: `JSP_ADDR_W] == INDEX);
  endfunction : addr_hit

  // agreed hub signals from the third stage
  assign rise = q.s2[`JSP_B_TCK] && q.s3[`JSP_B_TCK] && !q.tck_lvl;
  assign hit = addr_hit(q.s3);
  assign cap_s = q.s3[`JSP_B_CAP];
  assign shf_s = q.s3[`JSP_B_SHF];
  assign upd_s = q.s3[`JSP_B_UPD];
  assign tdi_s = q.s3[`JSP_B_TDI];

  // synchronisers, chain state machine and source register
  always_comb begin
    n = q;
    n.s1 = {JTAG_ADDR, JTAG_UPDATE, JTAG_SHIFT, JTAG_CAPTURE, JTAG_SEL, JTAG_TDI, JTAG_TCK};
    n.s2 = q.s1;
    n.s3 = q.s2;
    if (q.s2[`JSP_B_TCK] == q.s3[`JSP_B_TCK]) begin
      n.tck_lvl = q.s3[`JSP_B_TCK];
    end
    if (rise && hit) begin
      if (cap_s) begin
        n.sh = CHAIN_W'(PROBE);
        n.tdo = PROBE[0];
        n.cnt = '0;
        n.st = JSP_SHIFT;
      end else if (shf_s) begin
        unique case (q.st)
          JSP_IDLE: begin
            n.st = JSP_IDLE; // shift without capture is ignored
          end
          JSP_SHIFT, JSP_FULL: begin
            n.sh = {tdi_s, q.sh[CHAIN_W-1:1]};
            n.tdo = (CHAIN_W > 1) ? q.sh[CHAIN_W > 1 ? 1 : 0] : tdi_s;
            if (q.st == JSP_SHIFT) begin
              n.cnt = q.cnt + `JSP_CNT_W'(1);
              if (q.cnt == `JSP_CNT_W'(CHAIN_W - 1)) begin
                n.st = JSP_FULL;
              end
            end
          end
        endcase
      end else if (upd_s) begin
        if (q.st == JSP_FULL) begin
          n.src = q.sh[SOURCE_W-1:0];
          n.xreq = !q.xreq;
        end
        n.st = JSP_IDLE;
      end
    end
  end

  // state register
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      q <= '{s1: '0, s2: '0, s3: '0, tck_lvl: 1'b0, st: JSP_IDLE, cnt: '0, sh: '0,
             tdo: 1'b0, src: INIT_VAL[SOURCE_W-1:0], xreq: `JSP_RST_TGL};
    end else begin
      q <= n;
    end
  end

  // hand the finished word to the source clock side
  assign xfer.req_tgl = q.xreq;
  assign xfer.data = q.src;

  jsp_src_sync #(
    .SOURCE_W(SOURCE_W),
    .INIT_VAL(INIT_VAL),
    .USE_ENA(SYNC_MODE && USE_ENA)
  ) u_src_sync (
    .src_clk(SOURCE_CLK),
    .sys_rst(SYS_RST),
    .src_ena(SOURCE_ENA),
    .link(xfer.rx),
    .src_out(sync_src)
  );

  // outputs, each from a flip-flop
  assign JTAG_TDO = q.tdo;
  assign SOURCE = SYNC_MODE ? sync_src : q.src;

  sequence s_hit_edge;
    rise && hit;
  endsequence

  sequence s_full_update;
    rise && hit && !cap_s && !shf_s && upd_s && (q.st == JSP_FULL);
  endsequence

  property p_capture;
    @(posedge CLK) disable iff (SYS_RST)
      s_hit_edge ##0 cap_s |=> (q.sh == CHAIN_W'($past(PROBE))) && (q.st == JSP_SHIFT);
  endproperty
  a_capture: assert property (p_capture) else $error("probe not captured");

  property p_tdo_first;
    @(posedge CLK) disable iff (SYS_RST)
      s_hit_edge ##0 cap_s |=> JTAG_TDO == $past(PROBE[0]);
  endproperty
  a_tdo_first: assert property (p_tdo_first) else $error("tdo not probe bit 0");

  property p_shift_in;
    @(posedge CLK) disable iff (SYS_RST)
      s_hit_edge ##0 (!cap_s && shf_s && q.st != JSP_IDLE) |=> q.sh[CHAIN_W-1] == $past(tdi_s);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("tdi not shifted in");

  property p_full_after;
    @(posedge CLK) disable iff (SYS_RST)
      s_hit_edge ##0 (!cap_s && shf_s && q.st == JSP_SHIFT &&
                      q.cnt == `JSP_CNT_W'(CHAIN_W - 1)) |=> q.st == JSP_FULL;
  endproperty
  a_full_after: assert property (p_full_after) else $error("chain not full after length");

  property p_write;
    @(posedge CLK) disable iff (SYS_RST)
      s_full_update |=> (q.src == $past(q.sh[SOURCE_W-1:0])) && (q.xreq != $past(q.xreq));
  endproperty
  a_write: assert property (p_write) else $error("source not written in one cycle");

  property p_no_partial;
    @(posedge CLK) disable iff (SYS_RST)
      s_hit_edge ##0 (!cap_s && !shf_s && upd_s && q.st != JSP_FULL) |=>
        $stable(q.src) && (q.st == JSP_IDLE);
  endproperty
  a_no_partial: assert property (p_no_partial) else $error("partial shift reached source");

  property p_hold;
    @(posedge CLK) disable iff (SYS_RST)
      !(rise && hit && !cap_s && !shf_s && upd_s && q.st == JSP_FULL) |=> $stable(q.src);
  endproperty
  a_hold: assert property (p_hold) else $error("source moved without a write");

  property p_not_addressed;
    @(posedge CLK) disable iff (SYS_RST)
      (rise && !hit) |=> $stable(q.sh) && $stable(q.st) && $stable(q.src);
  endproperty
  a_not_addressed: assert property (p_not_addressed) else $error("acted when not selected");

endmodule : jsp_top
